// ---- design/prog_ctrl_pkg.sv ----
// Constants for the one-time-programmable array control block
package prog_ctrl_pkg;
	// ************************************
	// Register map
	// ************************************
	localparam logic [7:0] PROGRAM_CONTROL_OFS = 8'h1C;
	localparam logic [7:0] MODE_STATUS_OFS     = 8'h20;
	localparam int         LATCH_BIT           = 1;
	localparam int         POWER_BIT           = 0;
	localparam logic [1:0] CONTROL_RESET       = 2'h0;
	// Reserved control bits read as zero
	localparam logic [5:0] RESERVED_READ       = 6'h00;
	// ************************************
	// Array window and mode
	// ************************************
	localparam logic [7:0] ARRAY_BASE_PAGE     = 8'h01;
	localparam int         ARRAY_ADDR_W        = 14;
	localparam int         MODE_PIN_HOLD_CYC   = 2;
	localparam int         BOOT_RESET_CYC      = 4064;
	typedef enum logic [0:0] {
		MODE_USER      = 1'b0,
		MODE_BOOTSTRAP = 1'b1
	} op_mode_e;
endpackage : prog_ctrl_pkg

// ---- design/mode_capture.sv ----
// Operating mode capture at reset release
`timescale 1ns/10ps
`default_nettype none
module mode_capture
	import prog_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Mode pins
	input  wire logic irq_high_voltage_i,
	input  wire logic mode_select_port_pin_i,
	// Result
	output op_mode_e  mode_o,
	output logic      mode_valid_o
);
	logic rst_seen;

	// ************************************
	// Sample pins on first edge after release
	// ************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_seen     <= 1'b1;
			mode_valid_o <= 1'b0;
			mode_o       <= MODE_USER;
		end else if (rst_seen) begin
			rst_seen     <= 1'b0;
			mode_valid_o <= 1'b1;
			if (irq_high_voltage_i && mode_select_port_pin_i) begin
				mode_o <= MODE_BOOTSTRAP;
			end else begin
				mode_o <= MODE_USER;
			end
		end
	end
endmodule : mode_capture
`default_nettype wire

// ---- design/prog_ctrl.sv ----
// Programming control register, array latches and mode select
// Overview of operation
// - Reset release with normal interrupt pin level enters user mode.
// - Reset release with high-voltage interrupt pin and port pin high enters bootstrap.
// - User mode fetches all vectors from the programmable array.
// - Control register at 0x1C; low two bits reset to zero.
// - Latch set: array writes capture address and data; reads blocked.
// - Latch clear: array serves normal reads.
// - Power bit drives array power; reads and acts zero unless latch set.
// - One write may clear both power and latch bits.
`timescale 1ns/10ps
`default_nettype none
module prog_ctrl
	import prog_ctrl_pkg::*;
#(
	parameter int ADDR_W = ARRAY_ADDR_W
)(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Avalon-MM register slave
	input  wire logic [7:0]        avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic [31:0]            avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// CPU array access
	input  wire logic              cpu_array_write_i,
	input  wire logic              cpu_array_read_i,
	input  wire logic [ADDR_W-1:0] cpu_array_addr_i,
	input  wire logic [7:0]        cpu_array_wdata_i,
	output logic [7:0]             cpu_array_rdata_o,
	output logic                   cpu_array_rvalid_o,
	// Array side
	input  wire logic [7:0]        array_rdata_i,
	output logic [ADDR_W-1:0]      array_addr_o,
	output logic [7:0]             array_latched_data_o,
	output logic                   array_read_en_o,
	output logic                   array_program_power_o,
	// Mode pins and mode
	input  wire logic              irq_high_voltage_i,
	input  wire logic              mode_select_port_pin_i,
	output logic                   bootstrap_mode_o,
	output logic                   vector_from_array_o
);
	logic              array_latch_control;
	logic              program_power_command;
	logic              rd_ack;
	logic              wr_fire;
	logic              sel_ctrl;
	logic              sel_mode;
	logic              mode_valid;
	logic [ADDR_W-1:0] latched_addr;
	op_mode_e          mode;

	// ************************************
	// Mode capture
	// ************************************
	mode_capture u_mode (
		.clk_i                  (clk_i),
		.rst_i                  (rst_i),
		.irq_high_voltage_i     (irq_high_voltage_i),
		.mode_select_port_pin_i (mode_select_port_pin_i),
		.mode_o                 (mode),
		.mode_valid_o           (mode_valid)
	);

	assign bootstrap_mode_o    = (mode == MODE_BOOTSTRAP);
	assign vector_from_array_o = (mode == MODE_USER);

	// ************************************
	// Bus slave
	// ************************************
	// Writes finish in one cycle, reads take one extra for registered data
	assign sel_ctrl          = (avs_address_i == PROGRAM_CONTROL_OFS);
	assign sel_mode          = (avs_address_i == MODE_STATUS_OFS);
	assign wr_fire           = avs_write_i && !avs_read_i;
	assign avs_waitrequest_o = avs_read_i && !rd_ack;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ack <= 1'b0;
		end else begin
			rd_ack <= avs_read_i && !rd_ack;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && !rd_ack) begin
			if (sel_ctrl) begin
				avs_readdata_o <= {24'h00_0000, RESERVED_READ, array_latch_control,
					program_power_command && array_latch_control};
			end else if (sel_mode) begin
				avs_readdata_o <= {30'h0000_0000, mode_valid, bootstrap_mode_o};
			end else begin
				avs_readdata_o <= 32'h0000_0000;
			end
		end
	end

	// ************************************
	// Control register
	// ************************************
	// control register reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{array_latch_control, program_power_command} <= CONTROL_RESET;
		end else if (wr_fire && sel_ctrl && avs_byteenable_i[0]) begin
			array_latch_control   <= avs_writedata_i[LATCH_BIT];
			program_power_command <= avs_writedata_i[POWER_BIT] && avs_writedata_i[LATCH_BIT];
		end else if (!array_latch_control) begin
			program_power_command <= 1'b0;
		end
	end

	assign array_program_power_o = program_power_command && array_latch_control;

	// ************************************
	// Array latches
	// ************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latched_addr         <= '0;
			array_latched_data_o <= 8'h00;
		end else if (array_latch_control && cpu_array_write_i) begin
			latched_addr         <= cpu_array_addr_i;
			array_latched_data_o <= cpu_array_wdata_i;
		end
	end

	assign array_addr_o    = array_latch_control ? latched_addr : cpu_array_addr_i;
	assign array_read_en_o = cpu_array_read_i && !array_latch_control;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_array_rdata_o  <= 8'h00;
			cpu_array_rvalid_o <= 1'b0;
		end else begin
			cpu_array_rvalid_o <= array_read_en_o;
			cpu_array_rdata_o  <= array_read_en_o ? array_rdata_i : 8'h00;
		end
	end
endmodule : prog_ctrl
`default_nettype wire

// ---- tb/prog_ctrl_props.sv ----
// Port checks for the programming control block
`timescale 1ns/10ps
`default_nettype none
module prog_ctrl_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic cpu_array_read_i,
	input wire logic cpu_array_rvalid_o,
	input wire logic array_read_en_o,
	input wire logic array_program_power_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_power_no_read: assert property (array_program_power_o |-> !array_read_en_o)
		else $error("power with reads");
	a_read_served: assert property (cpu_array_read_i && array_read_en_o |=> cpu_array_rvalid_o)
		else $error("no rvalid");
	a_rvalid_cause: assert property (cpu_array_rvalid_o |-> $past(array_read_en_o))
		else $error("rvalid while latched");
	a_en_needs_read: assert property (array_read_en_o |-> cpu_array_read_i)
		else $error("stray read enable");
	a_rvalid_read: assert property (cpu_array_rvalid_o |-> $past(cpu_array_read_i))
		else $error("rvalid without read");
	a_read_stalls: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
		else $error("read not stalled");
	a_read_one_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("read wait too long");
	a_write_no_wait: assert property (avs_write_i && !avs_read_i |-> !avs_waitrequest_o)
		else $error("write stalled");
	c_power: cover property (array_program_power_o);
	c_rvalid: cover property (cpu_array_rvalid_o);
	c_reg_read: cover property ($rose(avs_read_i));
endmodule : prog_ctrl_props
bind prog_ctrl prog_ctrl_props u_props (.*);
`default_nettype wire

// ---- tb/array_model.sv ----
// Behavioural programmable array beside the control block
`timescale 1ns/10ps
`default_nettype none
module array_model (
	input  wire logic        clk_i,
	input  wire logic [13:0] addr_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        rd_en_i,
	input  wire logic        power_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [16];
	always @(posedge clk_i) if (power_i) mem[addr_i[3:0]] <= data_i;
	// Unread array shows the inverted stored byte
	assign rdata_o = rd_en_i ? mem[addr_i[3:0]] : ~mem[addr_i[3:0]];
endmodule : array_model
`default_nettype wire

// ---- tb/prog_ctrl_tb_top.sv ----
// Self-checking bench for the programming control block
`timescale 1ns/10ps
`default_nettype none
module prog_ctrl_tb_top;
	import prog_ctrl_pkg::*;
	logic clk_i, rst_i, avs_read_i, avs_write_i, cpu_array_write_i, cpu_array_read_i;
	logic irq_high_voltage_i, mode_select_port_pin_i, avs_waitrequest_o, cpu_array_rvalid_o;
	logic array_read_en_o, array_program_power_o, bootstrap_mode_o, vector_from_array_o;
	logic [7:0] avs_address_i, cpu_array_wdata_i, cpu_array_rdata_o, array_rdata_i;
	logic [7:0] array_latched_data_o;
	logic [13:0] cpu_array_addr_i, array_addr_o;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	int n_errors, samples_checked, i;
	prog_ctrl u_dut (.*, .avs_byteenable_i(4'hF));
	array_model u_arr (.clk_i, .addr_i(array_addr_o), .data_i(array_latched_data_o),
		.rd_en_i(array_read_en_o), .power_i(array_program_power_o), .rdata_o(array_rdata_i));
	initial forever #2.5 clk_i = (clk_i === 1'b1) ? 1'b0 : 1'b1;
	task automatic end_sim;
		$display("compares %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string s, input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) n_errors++;
		if (g !== e) $display("[FAIL] %s expected %h seen %h", s, e, g);
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, w, !w};
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (avs_waitrequest_o !== 1'b0 && i < 50);
		// Answer taken at the same edge that sees waitrequest low
		q = avs_readdata_o;
		{avs_write_i, avs_read_i} <= 2'h0;
		chk("wait", i < 50, 1);
		if (i == 50) end_sim;
		@(negedge clk_i);
	endtask : bus
	task automatic cpu(input logic w, input logic [13:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{cpu_array_write_i, cpu_array_read_i, cpu_array_addr_i, cpu_array_wdata_i} <= {w, !w, a, d};
		@(posedge clk_i);
		{cpu_array_write_i, cpu_array_read_i} <= 2'h0;
		@(negedge clk_i);
	endtask : cpu
	task automatic boot(input logic h, input logic p, input int n);
		@(posedge clk_i);
		{rst_i, irq_high_voltage_i, mode_select_port_pin_i} <= {1'b1, h, p};
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
		// level held two edges past release
		repeat (2) @(posedge clk_i);
		irq_high_voltage_i <= 1'b0;
		@(negedge clk_i);
	endtask : boot
	initial begin
		rst_i = 1'b1;
		{avs_read_i, avs_write_i, cpu_array_write_i, cpu_array_read_i} = 4'h0;
		{irq_high_voltage_i, mode_select_port_pin_i, avs_address_i, avs_writedata_i} = '0;
		{cpu_array_addr_i, cpu_array_wdata_i} = '0;
		boot(1'b0, 1'b0, 10);
		chk("mode", bootstrap_mode_o, 0);
		chk("vector", vector_from_array_o, 1);
		bus(1'b0, MODE_STATUS_OFS, 0);
		chk("status", q, 32'h0000_0002);
		bus(1'b0, PROGRAM_CONTROL_OFS, 0);
		chk("reset", q, 0);
		bus(1'b1, PROGRAM_CONTROL_OFS, 1);
		chk("power", array_program_power_o, 0);
		bus(1'b0, PROGRAM_CONTROL_OFS, 0);
		chk("power read", q, 0);
		$display("reset test done");
		// programming supply taken as present from here on
		bus(1'b1, PROGRAM_CONTROL_OFS, 2);
		cpu(1'b1, 14'h5, 8'hA5);
		chk("data", array_latched_data_o, 8'hA5);
		cpu(1'b0, 14'h9, 0);
		chk("blocked", cpu_array_rvalid_o, 0);
		chk("latched addr", array_addr_o, 14'h5);
		bus(1'b1, PROGRAM_CONTROL_OFS, 3);
		bus(1'b0, PROGRAM_CONTROL_OFS, 0);
		chk("armed", q, 3);
		chk("power", array_program_power_o, 1);
		repeat (20) @(posedge clk_i); // scaled hold
		bus(1'b1, PROGRAM_CONTROL_OFS, 0);
		chk("off", array_program_power_o, 0);
		bus(1'b0, PROGRAM_CONTROL_OFS, 0);
		chk("cleared", q, 0);
		cpu(1'b0, 14'h5, 0);
		chk("rvalid", cpu_array_rvalid_o, 1);
		chk("rdata", cpu_array_rdata_o, 8'hA5);
		bus(1'b1, 8'h40, 1);
		bus(1'b0, 8'h40, 0);
		chk("unmapped", q, 0);
		$display("program test done");
		boot(1'b1, 1'b0, 10);
		chk("pin low", bootstrap_mode_o, 0);
		boot(1'b1, 1'b1, BOOT_RESET_CYC); // full hold
		chk("boot", bootstrap_mode_o, 1);
		chk("vector", vector_from_array_o, 0);
		bus(1'b0, MODE_STATUS_OFS, 0);
		chk("boot status", q, 32'h0000_0003);
		$display("bootstrap test done");
		end_sim;
	end
endmodule : prog_ctrl_tb_top
`default_nettype wire
